/* File: rtl/hv_pin_cfg_pkg.sv */
// Register map, field layout and carrier types of the high-voltage pin configuration slice
package hv_pin_cfg_pkg;
   // Byte offsets on the register port
   localparam logic [7:0] OFS_BANK0_OPEN_LOAD    = 8'h3a;
   localparam logic [7:0] OFS_BANK1_SHORT        = 8'h49;
   localparam logic [7:0] OFS_BANK1_OPEN_LOAD    = 8'h4a;
   localparam logic [7:0] OFS_HIGH_SIDE_OVERRIDE = 8'h71;
   localparam logic [7:0] OFS_OVERRIDE_UNLOCK    = 8'h7e;
   // Reset values
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam logic [7:0] RST_OVERRIDE  = 8'h00;
   // Key that arms one override write; value is arbitrary
   localparam logic [7:0] UNLOCK_KEY    = 8'ha5;
   // Field layout: 2-bit code per pin, pin n of a bank at bit CODE_W*n
   localparam int          CODE_W        = 2;
   localparam int          PINS          = 8;
   localparam int          UNLOCK_BIT    = 0;
   localparam logic [7:0]  READ_UNMAPPED = 8'h00;

   // Threshold codes towards the analog detectors
   typedef struct packed {
      logic [7:0] bank0_open_load;  // Pins 4..1, two bits each
      logic [7:0] bank1_short;      // Pins 8..5
      logic [7:0] bank1_open_load;  // Pins 8..5
   } threshold_codes_t;
endpackage

/* File: rtl/high_side_override_store.sv */
// Override byte backed by non-volatile memory, and the high-side driver gating it controls
`timescale 1ns/1ps
`default_nettype none
module high_side_override_store
   import hv_pin_cfg_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] nv_image_i,
   input  wire logic       wr_en_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic [7:0] hs_request_i,
   output logic      [7:0] override_o,
   output logic      [7:0] hs_enable_o,
   output logic            nv_program_o,
   output logic      [7:0] nv_data_o
);
   typedef struct packed {
      logic [7:0] ovr;
      logic       load_pending;
      logic       prog_pulse;
      logic [7:0] program_data;
   } store_state_t;

   store_state_t st_q, st_d;

   // Stored image is fetched after reset release; the strap style load keeps reset constant
   always_comb begin
      st_d = st_q;
      st_d.prog_pulse = 1'b0;
      if (st_q.load_pending) begin
         st_d.ovr          = nv_image_i;
         st_d.load_pending = 1'b0;
      end
      if (wr_en_i) begin
         st_d.ovr          = wr_data_i;
         st_d.prog_pulse   = 1'b1;
         st_d.program_data = wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= '{ovr: RST_OVERRIDE, load_pending: 1'b1, prog_pulse: 1'b0,
                   program_data: RST_OVERRIDE};
      end else begin
         st_q <= st_d;
      end
   end

   // A set bit forces the high side off, a clear bit passes the pin's own request
   assign hs_enable_o  = hs_request_i & ~st_q.ovr;
   assign override_o   = st_q.ovr;
   assign nv_program_o = st_q.prog_pulse;
   assign nv_data_o    = st_q.program_data;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   force_off_a: assert property (wr_en_i
      |=> hs_enable_o == (hs_request_i & ~$past(wr_data_i)))
      else $error("override write did not gate high side");
   low_pins_a: assert property (wr_en_i && wr_data_i[2:0] == 3'h7 ##1 !wr_en_i [*2]
      |-> hs_enable_o[2:0] == 3'h0)
      else $error("pins 1 to 3 not forced off");
   nv_program_a: assert property (wr_en_i
      |=> nv_program_o && nv_data_o == $past(wr_data_i) ##1 (!nv_program_o || $past(wr_en_i)))
      else $error("non-volatile program pulse wrong");
endmodule
`default_nettype wire

/* File: rtl/hv_pin_threshold_regs.sv */
// Threshold code registers and locked high-side override for the eight high-voltage pins
`timescale 1ns/1ps
`default_nettype none
module hv_pin_threshold_regs
   import hv_pin_cfg_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [7:0]       wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [7:0]       rdata_o,
   input  wire logic [7:0]       nv_image_i,
   input  wire logic [7:0]       hs_request_i,
   output logic      [7:0]       hs_enable_o,
   output logic      [7:0]       override_o,
   output logic                  nv_program_o,
   output logic      [7:0]       nv_data_o,
   output threshold_codes_t      codes_o
);
   typedef struct packed {
      threshold_codes_t codes;
      logic             armed;
      logic [7:0]       rdata;
   } regs_state_t;

   regs_state_t st_q, st_d;
   logic        ovr_write;
   // Per-pin views of the stored codes and override bits, named after the pin they serve
   logic [1:0]  pin1_open_load_code;
   logic [1:0]  pin2_open_load_code;
   logic [1:0]  pin5_short_code;
   logic [1:0]  pin6_short_code;
   logic [1:0]  pin7_short_code;
   logic [1:0]  pin8_short_code;
   logic [1:0]  pin5_open_load_code;
   logic [1:0]  pin6_open_load_code;
   logic [1:0]  pin7_open_load_code;
   logic [1:0]  pin8_open_load_code;
   logic        pin1_high_side_force_off;
   logic        pin2_high_side_force_off;
   logic        pin3_high_side_force_off;
   logic        pin4_high_side_force_off;
   logic        pin5_high_side_force_off;
   logic        pin6_high_side_force_off;
   logic        pin7_high_side_force_off;
   logic        pin8_high_side_force_off;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Code of one pin slot in a bank byte; slot 0 is the lowest pin of that bank
   function automatic logic [1:0] pin_code(input logic [7:0] bank, input int slot);
      pin_code = bank[slot*CODE_W +: CODE_W];
   endfunction

   // Override write only goes through while armed; a stray write can't reprogram memory
   assign ovr_write = wr_i && hit(addr_i, OFS_HIGH_SIDE_OVERRIDE) && st_q.armed;

   // Register writes, unlock sequencing and the one-cycle-late read answer
   always_comb begin
      st_d = st_q;
      st_d.rdata = READ_UNMAPPED;
      if (wr_i) begin
         st_d.armed = 1'b0;  // Any write other than the key disarms
         if (hit(addr_i, OFS_BANK0_OPEN_LOAD)) st_d.codes.bank0_open_load = wdata_i;
         if (hit(addr_i, OFS_BANK1_SHORT)) st_d.codes.bank1_short = wdata_i;
         if (hit(addr_i, OFS_BANK1_OPEN_LOAD)) st_d.codes.bank1_open_load = wdata_i;
         if (hit(addr_i, OFS_OVERRIDE_UNLOCK)) st_d.armed = (wdata_i == UNLOCK_KEY);
      end
      if (rd_i) begin
         if (hit(addr_i, OFS_BANK0_OPEN_LOAD)) st_d.rdata = st_q.codes.bank0_open_load;
         if (hit(addr_i, OFS_BANK1_SHORT)) st_d.rdata = st_q.codes.bank1_short;
         if (hit(addr_i, OFS_BANK1_OPEN_LOAD)) st_d.rdata = st_q.codes.bank1_open_load;
         if (hit(addr_i, OFS_HIGH_SIDE_OVERRIDE)) st_d.rdata = override_o;
         if (hit(addr_i, OFS_OVERRIDE_UNLOCK)) begin
            st_d.rdata[UNLOCK_BIT] = st_q.armed;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= '{codes: '{RST_THRESHOLD, RST_THRESHOLD, RST_THRESHOLD},
                   armed: 1'b0, rdata: READ_UNMAPPED};
      end else begin
         st_q <= st_d;
      end
   end

   // Codes leave as stored; the analog side decides what each condition means
   assign codes_o = st_q.codes;
   assign rdata_o = st_q.rdata;

   // Slot views only; nothing here alters a code on its way to the detectors
   assign pin1_open_load_code = pin_code(st_q.codes.bank0_open_load, 0);
   assign pin2_open_load_code = pin_code(st_q.codes.bank0_open_load, 1);
   assign pin5_short_code     = pin_code(st_q.codes.bank1_short, 0);
   assign pin6_short_code     = pin_code(st_q.codes.bank1_short, 1);
   assign pin7_short_code     = pin_code(st_q.codes.bank1_short, 2);
   assign pin8_short_code     = pin_code(st_q.codes.bank1_short, 3);
   assign pin5_open_load_code = pin_code(st_q.codes.bank1_open_load, 0);
   assign pin6_open_load_code = pin_code(st_q.codes.bank1_open_load, 1);
   assign pin7_open_load_code = pin_code(st_q.codes.bank1_open_load, 2);
   assign pin8_open_load_code = pin_code(st_q.codes.bank1_open_load, 3);

   // Override bit n belongs to pin n+1
   assign pin8_high_side_force_off = override_o[7];
   assign pin7_high_side_force_off = override_o[6];
   assign pin6_high_side_force_off = override_o[5];
   assign pin5_high_side_force_off = override_o[4];
   assign pin4_high_side_force_off = override_o[3];
   assign pin3_high_side_force_off = override_o[2];
   assign pin2_high_side_force_off = override_o[1];
   assign pin1_high_side_force_off = override_o[0];

   // Bit n of the override byte belongs to pin n+1
   high_side_override_store high_side_override_store_inst (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .nv_image_i   (nv_image_i),
      .wr_en_i      (ovr_write),
      .wr_data_i    (wdata_i),
      .hs_request_i (hs_request_i),
      .override_o   (override_o),
      .hs_enable_o  (hs_enable_o),
      .nv_program_o (nv_program_o),
      .nv_data_o    (nv_data_o)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Register behaviour on the bus; the bank 0 write check compares bits 3:0 only
   bank0_write_a: assert property (wr_i && addr_i == OFS_BANK0_OPEN_LOAD
      |=> codes_o.bank0_open_load[3:0] == $past(wdata_i[3:0]))
      else $error("bank 0 open-load codes not stored");
   bank0_hold_a: assert property (!(wr_i && addr_i == OFS_BANK0_OPEN_LOAD)
      |=> $stable(codes_o.bank0_open_load))
      else $error("bank 0 open-load codes changed without write");
   bank0_read_a: assert property (rd_i && addr_i == OFS_BANK0_OPEN_LOAD
      |=> rdata_o == $past(codes_o.bank0_open_load))
      else $error("bank 0 open-load codes read back wrong");
   short_read_a: assert property (wr_i && addr_i == OFS_BANK1_SHORT
      ##1 rd_i && addr_i == OFS_BANK1_SHORT
      |=> rdata_o == $past(wdata_i, 2))
      else $error("bank 1 short codes read back wrong");
   short_hold_a: assert property (!(wr_i && addr_i == OFS_BANK1_SHORT)
      |=> $stable(codes_o.bank1_short))
      else $error("bank 1 short codes changed without write");
   open_load_hold_a: assert property (!(wr_i && addr_i == OFS_BANK1_OPEN_LOAD)
      |=> $stable(codes_o.bank1_open_load))
      else $error("bank 1 open-load codes changed without write");
   open_load_read_a: assert property (rd_i && addr_i == OFS_BANK1_OPEN_LOAD
      |=> rdata_o == $past(codes_o.bank1_open_load))
      else $error("bank 1 open-load codes read back wrong");
   override_read_a: assert property (rd_i && addr_i == OFS_HIGH_SIDE_OVERRIDE
      |=> rdata_o == $past(override_o))
      else $error("override byte read back wrong");
   // Read data stands one cycle only, so an idle bus reads as zero
   read_idle_a: assert property (!rd_i |=> rdata_o == READ_UNMAPPED)
      else $error("read data not cleared after its cycle");

   // Each pin slot takes its own pair of write data bits
   pin1_open_load_a: assert property (wr_i && addr_i == OFS_BANK0_OPEN_LOAD
      |=> pin1_open_load_code == $past(wdata_i[1:0]))
      else $error("pin 1 open-load code not taken");
   pin2_open_load_a: assert property (wr_i && addr_i == OFS_BANK0_OPEN_LOAD
      |=> pin2_open_load_code == $past(wdata_i[3:2]))
      else $error("pin 2 open-load code not taken");
   pin5_short_a: assert property (wr_i && addr_i == OFS_BANK1_SHORT
      |=> pin5_short_code == $past(wdata_i[1:0]))
      else $error("pin 5 short code not taken");
   pin6_short_a: assert property (wr_i && addr_i == OFS_BANK1_SHORT
      |=> pin6_short_code == $past(wdata_i[3:2]))
      else $error("pin 6 short code not taken");
   pin7_short_a: assert property (wr_i && addr_i == OFS_BANK1_SHORT
      |=> pin7_short_code == $past(wdata_i[5:4]))
      else $error("pin 7 short code not taken");
   pin8_short_a: assert property (wr_i && addr_i == OFS_BANK1_SHORT
      |=> pin8_short_code == $past(wdata_i[7:6]))
      else $error("pin 8 short code not taken");
   pin5_open_load_a: assert property (wr_i && addr_i == OFS_BANK1_OPEN_LOAD
      |=> pin5_open_load_code == $past(wdata_i[1:0]))
      else $error("pin 5 open-load code not taken");
   pin6_open_load_a: assert property (wr_i && addr_i == OFS_BANK1_OPEN_LOAD
      |=> pin6_open_load_code == $past(wdata_i[3:2]))
      else $error("pin 6 open-load code not taken");
   pin7_open_load_a: assert property (wr_i && addr_i == OFS_BANK1_OPEN_LOAD
      |=> pin7_open_load_code == $past(wdata_i[5:4]))
      else $error("pin 7 open-load code not taken");
   pin8_open_load_a: assert property (wr_i && addr_i == OFS_BANK1_OPEN_LOAD
      |=> pin8_open_load_code == $past(wdata_i[7:6]))
      else $error("pin 8 open-load code not taken");

   // Unlock sequencing; the image load at reset release is not a bus write
   locked_write_a: assert property (wr_i && addr_i == OFS_HIGH_SIDE_OVERRIDE && !st_q.armed
      && !$past(reset_i) |=> !nv_program_o && $stable(override_o))
      else $error("override changed while locked");
   unlock_write_a: assert property (wr_i && addr_i == OFS_OVERRIDE_UNLOCK
      && wdata_i == UNLOCK_KEY ##1 wr_i && addr_i == OFS_HIGH_SIDE_OVERRIDE
      |=> override_o == $past(wdata_i) && nv_program_o)
      else $error("unlocked override write not taken");
   disarm_a: assert property (wr_i && addr_i != OFS_OVERRIDE_UNLOCK |=> !st_q.armed)
      else $error("unlock survived a second write");
   unlock_status_a: assert property (rd_i && addr_i == OFS_OVERRIDE_UNLOCK
      |=> rdata_o[UNLOCK_BIT] == $past(st_q.armed))
      else $error("unlock status read back wrong");

   // Pin gating: clear bits pass the request, set bits hold the high side off
   follow_pins_a: assert property ((hs_enable_o & ~override_o) == (hs_request_i & ~override_o))
      else $error("unforced pin does not follow its request");
   pin8_forced_a: assert property (pin8_high_side_force_off |-> !hs_enable_o[7])
      else $error("pin 8 high side not held off");
   pin7_forced_a: assert property (pin7_high_side_force_off |-> !hs_enable_o[6])
      else $error("pin 7 high side not held off");
   pin6_forced_a: assert property (pin6_high_side_force_off |-> !hs_enable_o[5])
      else $error("pin 6 high side not held off");
   pin5_forced_a: assert property (pin5_high_side_force_off |-> !hs_enable_o[4])
      else $error("pin 5 high side not held off");
   pin4_forced_a: assert property (pin4_high_side_force_off |-> !hs_enable_o[3])
      else $error("pin 4 high side not held off");
   pin3_forced_a: assert property (pin3_high_side_force_off |-> !hs_enable_o[2])
      else $error("pin 3 high side not held off");
   pin2_forced_a: assert property (pin2_high_side_force_off |-> !hs_enable_o[1])
      else $error("pin 2 high side not held off");
   pin1_forced_a: assert property (pin1_high_side_force_off |-> !hs_enable_o[0])
      else $error("pin 1 high side not held off");
endmodule
`default_nettype wire

/* File: verif/hv_pin_driver_threshold_override_regs_bench.sv */
// Self-checking bench for the high-voltage pin threshold and override registers
`timescale 1ns/1ps
`default_nettype none
module hv_pin_driver_threshold_override_regs_bench;
   import hv_pin_cfg_pkg::*;
   logic             clk_i        = 1'b0;
   logic             reset_i      = 1'b1;
   logic [7:0]       addr_i       = 8'h00;
   logic [7:0]       wdata_i      = 8'h00;
   logic             wr_i         = 1'b0;
   logic             rd_i         = 1'b0;
   logic [7:0]       nv_image_i   = 8'h5a;
   logic [7:0]       hs_request_i = 8'h00;
   logic [7:0]       rdata_o;
   logic [7:0]       hs_enable_o;
   logic [7:0]       override_o;
   logic             nv_program_o;
   logic [7:0]       nv_data_o;
   threshold_codes_t codes_o;
   int               miscompares  = 0;
   int               checked      = 0;

   hv_pin_threshold_regs hv_pin_threshold_regs_inst (.clk_i(clk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .nv_image_i(nv_image_i), .hs_request_i(hs_request_i), .hs_enable_o(hs_enable_o),
      .override_o(override_o), .nv_program_o(nv_program_o), .nv_data_o(nv_data_o),
      .codes_o(codes_o));

   // 100 ns period
   always #50 clk_i = ~clk_i;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe; returns at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) begin wr_i <= 1'b1; addr_i <= a; wdata_i <= d; end
      @(posedge clk_i) wr_i <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i) begin rd_i <= 1'b1; addr_i <= a; end
      @(posedge clk_i) rd_i <= 1'b0;
      #1 check(rdata_o, exp);
   endtask

   // Two writes with no gap between them
   task automatic wr_pair(input logic [7:0] a0, input logic [7:0] d0,
                          input logic [7:0] a1, input logic [7:0] d1);
      @(posedge clk_i) begin wr_i <= 1'b1; addr_i <= a0; wdata_i <= d0; end
      @(posedge clk_i) begin addr_i <= a1; wdata_i <= d1; end
      @(posedge clk_i) wr_i <= 1'b0;
   endtask

   // Write, then read the same address in the very next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) begin wr_i <= 1'b1; addr_i <= a; wdata_i <= d; end
      @(posedge clk_i) begin wr_i <= 1'b0; rd_i <= 1'b1; end
      @(posedge clk_i) rd_i <= 1'b0;
      #1 check(rdata_o, d);
   endtask

   // Two request patterns, so both levels of bits 0, 1, 5 and 7 meet the override
   task automatic gate(input logic [7:0] ov);
      @(posedge clk_i) hs_request_i <= 8'hff;
      #1 check(hs_enable_o, {16'h0000, ~ov});
      @(posedge clk_i) hs_request_i <= 8'h5c;
      #1 check(hs_enable_o, 8'h5c & ~ov);
   endtask

   task automatic t_thresholds;
      logic [7:0] v;
      // Each pattern holds all four codes once; across the two passes every pin position sees two of them
      for (int i = 0; i < 2; i++) begin
         v = i ? 8'h1b : 8'he4;
         wr(OFS_BANK0_OPEN_LOAD, v);
         wr(OFS_BANK1_SHORT, ~v);
         wr(OFS_BANK1_OPEN_LOAD, {v[3:0], v[7:4]});
         #1 check(codes_o, {v, ~v, v[3:0], v[7:4]});
         rd(OFS_BANK0_OPEN_LOAD, v);
         rd(OFS_BANK1_SHORT, ~v);
         rd(OFS_BANK1_OPEN_LOAD, {v[3:0], v[7:4]});
      end
      wr_rd(OFS_BANK1_SHORT, 8'h9c);
      wr_rd(OFS_BANK0_OPEN_LOAD, 8'h36);
      $display("test thresholds done");
   endtask

   task automatic t_override;
      // Unarmed write and a write after a disarming one are both refused
      wr(OFS_HIGH_SIDE_OVERRIDE, 8'h00);
      #1 check(override_o, 8'h5a);
      wr(OFS_OVERRIDE_UNLOCK, UNLOCK_KEY);
      wr(8'h10, 8'hff);
      wr(OFS_HIGH_SIDE_OVERRIDE, 8'h00);
      #1 check({nv_program_o, override_o}, {1'b0, 8'h5a});
      wr(OFS_OVERRIDE_UNLOCK, UNLOCK_KEY);
      wr(OFS_HIGH_SIDE_OVERRIDE, 8'hc3);
      #1 check({nv_program_o, nv_data_o, override_o}, {1'b1, 8'hc3, 8'hc3});
      @(posedge clk_i);
      #1 check(nv_program_o, 1'b0);
      rd(OFS_HIGH_SIDE_OVERRIDE, 8'hc3);
      gate(8'hc3);
      rd(8'h10, READ_UNMAPPED);
      // Status bit shows the arming; a back-to-back key and write forces pins 1 to 3 and 5
      wr(OFS_OVERRIDE_UNLOCK, UNLOCK_KEY);
      rd(OFS_OVERRIDE_UNLOCK, 8'h01);
      wr_pair(OFS_OVERRIDE_UNLOCK, UNLOCK_KEY, OFS_HIGH_SIDE_OVERRIDE, 8'h17);
      #1 check({nv_program_o, nv_data_o, override_o}, {1'b1, 8'h17, 8'h17});
      rd(OFS_OVERRIDE_UNLOCK, 8'h00);
      gate(8'h17);
      $display("test override done");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Reset, image load, then the scenarios
   initial begin
      repeat (10) @(posedge clk_i);
      #1 check(codes_o, 24'h000000);
      @(posedge clk_i) reset_i <= 1'b0;
      @(posedge clk_i);
      #1 check(override_o, 8'h5a);
      gate(8'h5a);
      $display("test reset and image done");
      t_thresholds();
      t_override();
      finish_test();
   end
endmodule
`default_nettype wire
